// *** src/rsss_pkg.sv ***
// Shared constants and types of the readout sequencer
package rsss_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CFG_A    = 8'h00;
  localparam logic [7:0] A_CFG_D    = 8'h04;
  localparam logic [7:0] A_NWIN     = 8'h08;
  localparam logic [7:0] A_RSTLEN   = 8'h0c;
  localparam logic [7:0] A_TINT     = 8'h10;
  localparam logic [7:0] A_DS_TIMER = 8'h14;
  localparam logic [7:0] A_TS_TIMER = 8'h18;
  localparam logic [7:0] A_STATUS   = 8'h1c;
  localparam logic [1:0] A_WIN_PAGE = 2'h1;   // 0x40..0x7f, 0x10 per window
  localparam logic [1:0] WF_XSTART  = 2'h0;
  localparam logic [1:0] WF_XKERN   = 2'h1;
  localparam logic [1:0] WF_YSTART  = 2'h2;
  localparam logic [1:0] WF_YEND    = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFGA_START = 0;
  localparam int CFGA_SLAVE = 1;
  localparam int CFGA_DS_EN = 5;
  localparam int CFGA_TS_EN = 6;
  localparam int CFGD_SUB   = 0;
  localparam int CFGD_COLOR = 1;
  localparam int CFGD_REVX  = 6;
  localparam int CFGD_REVY  = 7;
  localparam logic [7:0]  CFG_RST   = 8'h00;
  localparam logic [2:0]  NWIN_RST  = 3'h1;
  localparam logic [23:0] TIMER_RST = 24'h000000;
  localparam logic [5:0]  XK_RST    = 6'h36;
  localparam logic [10:0] YE_RST    = 11'h3ff;

  // ----------------------------------------------------------------
  // Geometry and counts
  // ----------------------------------------------------------------
  localparam int          MAX_WIN    = 4;
  localparam logic [5:0]  UNITS_FULL = 6'h36;   // 54 slots of 24 pixels
  localparam logic [5:0]  UNITS_SUB  = 6'h1b;   // 27 pairs of 48 pixels
  localparam int          PIX_FULL   = 24;
  localparam int          PIX_SUB    = 48;
  localparam logic [7:0]  FOT_SLOTS  = 8'h04;

  // ----------------------------------------------------------------
  // Sync channel codes
  // ----------------------------------------------------------------
  localparam logic [9:0] SC_FRAME_BEGIN = 10'h059;
  localparam logic [9:0] SC_LINE_BEGIN  = 10'h056;
  localparam logic [9:0] SC_FRAME_END   = 10'h05a;
  localparam logic [9:0] SC_LINE_END    = 10'h055;
  localparam logic [9:0] SC_GBC         = 10'h0a9;
  localparam logic [9:0] SC_CRC         = 10'h0a6;
  localparam logic [9:0] SC_FPN         = 10'h13c;
  localparam logic [9:0] SC_DATA        = 10'h193;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RST   = 6'b000010,
    ST_INTEG = 6'b000100,
    ST_FOT   = 6'b001000,
    ST_DUMMY = 6'b010000,
    ST_LINES = 6'b100000
  } rsss_state_t;

  typedef enum logic [4:0] {
    PH_START = 5'b00001,
    PH_DATA  = 5'b00010,
    PH_GBC   = 5'b00100,
    PH_CRC   = 5'b01000,
    PH_END   = 5'b10000
  } rsss_phase_t;

  typedef enum logic [1:0] {
    MD_FULL  = 2'h0,
    MD_MONO  = 2'h1,
    MD_COLOR = 2'h2
  } rsss_mode_t;

  typedef logic [11:0][10:0] rsss_cols_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] sync;
    logic [1:0] win;
    logic [10:0] line;
    logic [10:0] row;
    rsss_cols_t cols;
  } rsss_slot_t;

  typedef struct packed {
    logic pix_reset;
    logic second_slope;
    logic third_slope;
  } rsss_pix_t;

endpackage

// *** src/rsss_remap.sv ***
// Pixel-to-channel column remap for one timeslot half
`timescale 1ns/1ps
`default_nettype none
module rsss_remap (
  // Slot selection
  input  wire rsss_pkg::rsss_mode_t mode,
  input  wire logic [5:0]           unit,
  input  wire logic                 half,
  // Column of each of the twelve channels
  output rsss_pkg::rsss_cols_t      cols
);
  // ----------------------------------------------------------------
  // Per channel column arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    int base;
    int off;
    base = 0;
    off  = 0;
    cols = '0;
    for (int c = 0; c < 12; c++) begin
      unique case (mode)
        rsss_pkg::MD_FULL: begin
          base = rsss_pkg::PIX_FULL * int'(unit);
          if (!unit[0]) off = 2 * c + int'(half);
          else off = 23 - 2 * c - int'(half);
        end
        rsss_pkg::MD_MONO: begin
          base = rsss_pkg::PIX_SUB * int'(unit);
          off  = half ? 46 - 2 * c : 2 * c;      // RL2
        end
        default: begin
          base = rsss_pkg::PIX_SUB * int'(unit);
          if (c % 2 == 0) off = 2 * c + int'(half);      // RL1
          else off = 47 - 2 * c - int'(half);            // RL1
        end
      endcase
      cols[c] = 11'(base + off);
    end
  end
endmodule
`default_nettype wire

// *** src/rsss_sequencer.sv ***
// Windowed readout sequencer with slope control and APB registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1 - Color subsample: 27 pairs, mirrored odd channels
// RL2 - Mono subsample: ascending a, descending b
// RL3 - Sync sequence differs when window holds slot 54
// RL4 - Slot 54 always read for grey/black
// RL5 - Full-width dummy line once per frame first
// RL6 - Horizontal start counts units of 24 pixels
// RL7 - Kernel count covers 24 or 48 columns
// RL8 - Controller keeps end line above start line
// RL9 - Reverse X/Y by mode bits 6, 7
// RL10 - Controller reprograms starts for reverse scan
// RL11 - Up to four windows read in order
// RL12 - Active window count one to four
// RL13 - Controller keeps readout within reset plus integration
// RL14 - Overhead period, then windows line by line
// RL15 - Integration limited to summed window heights
// RL16 - Controller prefers clock-cycle timer units
// RL17 - Second and third reset before integration ends
// RL18 - Slope enables bits 5, 6 with timers
// RL19 - Controller places slope instants, typically 90/99%
// RL20 - Slave mode ignores internal timer values
// RL21 - Controller drives integration pins in slave mode
// RL22 - Sync codes on separate thirteenth channel
module rsss_sequencer #(
  parameter int unsigned ROWS        = 1024,
  parameter int unsigned LINE_CYCLES = 64
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pins from outside
  input  wire logic                link_clk,
  input  wire logic                int_time_pin,
  input  wire logic                second_slope_pin,
  input  wire logic                third_slope_pin,
  // Readout stream and pixel control
  output rsss_pkg::rsss_slot_t     slot_q,
  output rsss_pkg::rsss_pix_t      pix_q
);
  import rsss_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]  cfga_q, cfgd_q;
  logic [2:0]  nwin_q;
  logic [23:0] rstlen_q, tint_q, dst_q, tst_q;
  logic [5:0]  xs_q [MAX_WIN];
  logic [5:0]  xk_q [MAX_WIN];
  logic [10:0] ys_q [MAX_WIN];
  logic [10:0] ye_q [MAX_WIN];
  logic        start_q;
  logic [31:0] prdata_q;
  logic        perr_q;

  // Sequencer state
  rsss_state_t st_q, st_d;
  rsss_phase_t ph_q, ph_d;
  logic [31:0] cnt_q, cnt_d;
  logic [5:0]  u_q, u_d;
  logic        half_q, half_d;
  logic [1:0]  win_q, win_d;
  logic [10:0] y_q, y_d;
  logic [3:0]  sy1_q, sy2_q, sy3_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire         wr_en    = psel & penable & pwrite;
  wire         setup    = psel & ~penable;
  wire         win_hit  = (paddr[7:6] == A_WIN_PAGE);
  wire [1:0]   win_sel  = paddr[5:4];
  wire [1:0]   fld_sel  = paddr[3:2];
  wire         cfga_hit = (paddr == A_CFG_A);
  wire         cfgd_hit = (paddr == A_CFG_D);
  wire         nwin_hit = (paddr == A_NWIN);
  wire         rlen_hit = (paddr == A_RSTLEN);
  wire         tint_hit = (paddr == A_TINT);
  wire         dst_hit  = (paddr == A_DS_TIMER);
  wire         tst_hit  = (paddr == A_TS_TIMER);
  wire         stat_hit = (paddr == A_STATUS);
  wire         mapped   = cfga_hit | cfgd_hit | nwin_hit | rlen_hit | tint_hit |
                          dst_hit | tst_hit | stat_hit | (win_hit & paddr[1:0] == 2'h0);

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = perr_q & psel & penable;

  // Mode decode
  wire sub    = cfgd_q[CFGD_SUB];
  wire slave  = cfga_q[CFGA_SLAVE];
  wire rev_x  = cfgd_q[CFGD_REVX];   // RL9
  wire rev_y  = cfgd_q[CFGD_REVY];   // RL9
  wire ds_en  = cfga_q[CFGA_DS_EN];  // RL18
  wire ts_en  = cfga_q[CFGA_TS_EN];  // RL18
  wire [2:0] nwin_eff = (nwin_q == 3'h0) ? 3'h1 : (nwin_q > 3'h4) ? 3'h4 : nwin_q;  // RL12

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (cfga_hit) rd_mux = {24'h0, cfga_q & 8'hfe};
    else if (cfgd_hit) rd_mux = {24'h0, cfgd_q};
    else if (nwin_hit) rd_mux = {29'h0, nwin_eff};  // RL12
    else if (rlen_hit) rd_mux = {8'h0, rstlen_q};
    else if (tint_hit) rd_mux = {8'h0, tint_q};
    else if (dst_hit) rd_mux = {8'h0, dst_q};
    else if (tst_hit) rd_mux = {8'h0, tst_q};
    else if (stat_hit) rd_mux = {5'h0, y_q, 6'h0, win_q, 2'h0, st_q};
    else if (win_hit) begin
      unique case (fld_sel)
        WF_XSTART: rd_mux = {26'h0, xs_q[win_sel]};
        WF_XKERN:  rd_mux = {26'h0, xk_q[win_sel]};
        WF_YSTART: rd_mux = {21'h0, ys_q[win_sel]};
        WF_YEND:   rd_mux = {21'h0, ye_q[win_sel]};
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= '0;
      perr_q   <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0 : rd_mux;
      perr_q   <= ~mapped;
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfga_q   <= CFG_RST;
      cfgd_q   <= CFG_RST;
      nwin_q   <= NWIN_RST;
      rstlen_q <= TIMER_RST;
      tint_q   <= TIMER_RST;
      dst_q    <= TIMER_RST;
      tst_q    <= TIMER_RST;
      start_q  <= 1'b0;
      for (int w = 0; w < MAX_WIN; w++) begin
        xs_q[w] <= '0;
        xk_q[w] <= XK_RST;
        ys_q[w] <= '0;
        ye_q[w] <= YE_RST;
      end
    end else begin
      start_q <= wr_en & cfga_hit & pwdata[CFGA_START];
      if (wr_en & cfga_hit) cfga_q <= pwdata[7:0];
      if (wr_en & cfgd_hit) cfgd_q <= pwdata[7:0];
      if (wr_en & nwin_hit) nwin_q <= pwdata[2:0];
      if (wr_en & rlen_hit) rstlen_q <= pwdata[23:0];
      if (wr_en & tint_hit) tint_q <= pwdata[23:0];
      if (wr_en & dst_hit) dst_q <= pwdata[23:0];
      if (wr_en & tst_hit) tst_q <= pwdata[23:0];
      if (wr_en & win_hit & fld_sel == WF_XSTART) xs_q[win_sel] <= pwdata[5:0];
      if (wr_en & win_hit & fld_sel == WF_XKERN) xk_q[win_sel] <= pwdata[5:0];
      if (wr_en & win_hit & fld_sel == WF_YSTART) ys_q[win_sel] <= pwdata[10:0];
      if (wr_en & win_hit & fld_sel == WF_YEND) ye_q[win_sel] <= pwdata[10:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
    end else begin
      sy1_q <= {third_slope_pin, second_slope_pin, int_time_pin, link_clk};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  wire tick     = sy2_q[0] & ~sy3_q[0];   // One timeslot per link rising edge
  wire int_rise = sy2_q[1] & ~sy3_q[1];
  wire int_fall = ~sy2_q[1] & sy3_q[1];

  // ----------------------------------------------------------------
  // Integration limit from window heights
  // ----------------------------------------------------------------
  logic [31:0] sum_h;
  always_comb begin
    sum_h = '0;
    for (int w = 0; w < MAX_WIN; w++) begin
      if (w < int'(nwin_eff)) sum_h = sum_h + 32'(ye_q[w] - ys_q[w]) + 32'h1;
    end
  end
  wire [31:0] tint_lim = 32'(sum_h * LINE_CYCLES);
  wire [31:0] tint_eff = (32'(tint_q) > tint_lim) ? tint_lim : 32'(tint_q);  // RL15
  wire [31:0] remain   = tint_eff - cnt_q;

  // ----------------------------------------------------------------
  // Horizontal geometry of the current line
  // ----------------------------------------------------------------
  wire         dummy   = (st_q == ST_DUMMY);
  wire [5:0]   units   = (sub & ~dummy) ? UNITS_SUB : UNITS_FULL;
  wire [5:0]   last_u  = units - 6'h1;
  wire [5:0]   cur_xs  = xs_q[win_q];
  wire [5:0]   cur_xk  = (xk_q[win_q] == 6'h0) ? 6'h1 : xk_q[win_q];
  wire [10:0]  cur_ys  = ys_q[win_q];
  wire [10:0]  cur_ye  = ye_q[win_q];
  wire [5:0]   st_unit = dummy ? 6'h0 : (sub ? {1'b0, cur_xs[5:1]} : cur_xs);  // RL6
  wire [5:0]   n_units = dummy ? UNITS_FULL : cur_xk;                           // RL7
  wire [6:0]   log_u   = {1'b0, st_unit} + {1'b0, u_q};
  wire [5:0]   phy_u   = (rev_x & ~dummy) ? last_u - log_u[5:0] : log_u[5:0];   // RL9
  wire [6:0]   w_end   = {1'b0, st_unit} + {1'b0, cur_xk};
  wire         has_54  = rev_x ? (st_unit == 6'h0) : (w_end > {1'b0, last_u});
  wire         u_last  = (u_q == n_units - 6'h1) | (log_u >= {1'b0, last_u});
  wire         y_first = (y_q == cur_ys);
  wire         y_last  = (y_q == cur_ye);
  wire         win_end = ({1'b0, win_q} == nwin_eff - 3'h1);

  // Column map for the slot being emitted
  rsss_mode_t  map_mode;
  rsss_cols_t  map_cols;
  assign map_mode = (sub & ~dummy) ? (cfgd_q[CFGD_COLOR] ? MD_COLOR : MD_MONO) : MD_FULL;

  rsss_remap u_remap (
    .mode (map_mode),
    .unit ((ph_q == PH_GBC) ? last_u : phy_u),
    .half (half_q),
    .cols (map_cols)
  );

  // ----------------------------------------------------------------
  // Sync code and slot contents
  // ----------------------------------------------------------------
  logic [9:0] sync_code;
  always_comb begin
    unique case (ph_q)
      PH_START: sync_code = (dummy | y_first) ? SC_FRAME_BEGIN : SC_LINE_BEGIN;  // RL22
      PH_DATA: begin
        if (dummy) sync_code = SC_FPN;
        else if (phy_u == last_u) sync_code = SC_GBC;   // RL3
        else sync_code = SC_DATA;
      end
      PH_GBC:  sync_code = SC_GBC;                      // RL4
      PH_CRC:  sync_code = SC_CRC;
      default: sync_code = (~dummy & y_last) ? SC_FRAME_END : SC_LINE_END;
    endcase
  end

  wire         emit     = tick & (dummy | st_q == ST_LINES);
  wire [10:0]  out_line = dummy ? 11'h0 : y_q - cur_ys;
  wire [10:0]  phy_row  = (rev_y & ~dummy) ? 11'(ROWS - 1) - y_q : y_q;  // RL9

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    ph_d   = ph_q;
    cnt_d  = cnt_q;
    u_d    = u_q;
    half_d = half_q;
    win_d  = win_q;
    y_d    = y_q;
    unique case (st_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (!slave && start_q) st_d = ST_RST;
        else if (slave && int_rise) st_d = ST_INTEG;   // RL20
      end
      ST_RST: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(rstlen_q)) begin
          st_d  = ST_INTEG;
          cnt_d = '0;
        end
      end
      ST_INTEG: begin
        cnt_d = cnt_q + 32'h1;
        if (slave ? int_fall : (cnt_q >= tint_eff)) begin  // RL20
          st_d  = ST_FOT;
          cnt_d = '0;
        end
      end
      ST_FOT: begin
        if (tick) cnt_d = cnt_q + 32'h1;
        if (tick && cnt_q >= 32'(FOT_SLOTS - 8'h1)) begin  // RL14
          st_d   = ST_DUMMY;                                // RL5
          ph_d   = PH_START;
          u_d    = '0;
          half_d = 1'b0;
          win_d  = '0;
        end
      end
      default: begin
        if (tick) begin
          unique case (ph_q)
            PH_START: ph_d = PH_DATA;
            PH_DATA: begin
              half_d = ~half_q;
              if (half_q && u_last) ph_d = (dummy | has_54) ? PH_CRC : PH_GBC;  // RL4
              else if (half_q) u_d = u_q + 6'h1;
            end
            PH_GBC: begin
              half_d = ~half_q;
              if (half_q) ph_d = PH_CRC;
            end
            PH_CRC: ph_d = PH_END;
            default: begin
              ph_d   = PH_START;
              u_d    = '0;
              half_d = 1'b0;
              if (dummy) begin
                st_d = ST_LINES;          // RL14
                y_d  = ys_q[0];
              end else if (!y_last) begin
                y_d = y_q + 11'h1;
              end else if (win_end) begin
                st_d = ST_IDLE;
              end else begin
                win_d = win_q + 2'h1;     // RL11
                y_d   = ys_q[win_q + 2'h1];
              end
            end
          endcase
        end
      end
    endcase
  end

  // Sequencer state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= ST_IDLE;
      ph_q   <= PH_START;
      cnt_q  <= '0;
      u_q    <= '0;
      half_q <= 1'b0;
      win_q  <= '0;
      y_q    <= '0;
    end else begin
      st_q   <= st_d;
      ph_q   <= ph_d;
      cnt_q  <= cnt_d;
      u_q    <= u_d;
      half_q <= half_d;
      win_q  <= win_d;
      y_q    <= y_d;
    end
  end

  // ----------------------------------------------------------------
  // Output slot register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_q <= '0;
    end else begin
      slot_q.valid <= emit;
      if (emit) begin
        slot_q.sync <= sync_code;
        slot_q.win  <= win_q;
        slot_q.line <= out_line;
        slot_q.row  <= phy_row;
        slot_q.cols <= ((ph_q == PH_DATA) | (ph_q == PH_GBC)) ? map_cols : '0;  // RL1
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel reset and slope pulses
  // ----------------------------------------------------------------
  wire integ   = (st_q == ST_INTEG);
  wire ds_hit  = integ & ds_en & (remain == 32'(dst_q));   // RL17
  wire ts_hit  = integ & ts_en & (remain == 32'(tst_q));   // RL17

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pix_q <= '0;
    end else if (slave) begin
      pix_q.pix_reset    <= ~sy2_q[1];   // RL20
      pix_q.second_slope <= sy2_q[2];
      pix_q.third_slope  <= sy2_q[3];
    end else begin
      pix_q.pix_reset    <= (st_q == ST_RST);
      pix_q.second_slope <= ds_hit;      // RL18
      pix_q.third_slope  <= ts_hit;      // RL18
    end
  end
endmodule
`default_nettype wire

// *** verification/rsss_checker.sv ***
// Port checker for the readout sequencer
`timescale 1ns/1ps
`default_nettype none
module rsss_checker (
  // Clock, reset and bus answer
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Link pin and outputs
  input wire logic                 link_clk,
  input wire rsss_pkg::rsss_slot_t slot_q,
  input wire rsss_pkg::rsss_pix_t  pix_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Slot qualifiers
  wire logic v_w   = slot_q.valid;
  wire logic crc_w = v_w && slot_q.sync == rsss_pkg::SC_CRC;
  wire logic fpn_w = v_w && slot_q.sync == rsss_pkg::SC_FPN;
  wire logic dat_w = v_w && slot_q.sync == rsss_pkg::SC_DATA;
  // --------
  // Assertions
  // --------
  a_pready_high: assert property (pready) else $error("pready low");
  a_slverr_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  a_valid_pulse: assert property (v_w |=> !v_w) else $error("slot valid too long");
  a_valid_tick: assert property ($rose(v_w) |-> $past(link_clk, 2)) else $error("slot without tick");
  a_sync_legal: assert property (v_w |-> slot_q.sync inside {10'h059, 10'h056, 10'h05a,
    10'h055, 10'h0a9, 10'h0a6, 10'h13c, 10'h193}) else $error("bad sync code");
  a_crc_nocols: assert property (crc_w |-> slot_q.cols == '0) else $error("crc slot cols");
  a_dummy_line: assert property (fpn_w |-> slot_q.line == 11'h000) else $error("dummy line no");
  a_cols_range: assert property (dat_w |-> slot_q.cols[0] < 11'd1296
    && slot_q.cols[11] < 11'd1296) else $error("column out of array");
  // Main scenarios
  c_frame: cover property (v_w && slot_q.sync == rsss_pkg::SC_FRAME_END);
  c_slverr: cover property (pslverr);
  c_slope: cover property (pix_q.second_slope);
endmodule
bind rsss_sequencer rsss_checker u_chk (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .slot_q(slot_q), .pix_q(pix_q));
`default_nettype wire

// *** verification/rsss_link_model.sv ***
// Far-side model: link timing clock and slave integration pins
`timescale 1ns/1ps
`default_nettype none
module rsss_link_model (
  // Controls from the bench
  input  wire logic run,
  input  wire logic int_lvl,
  input  wire logic ds_lvl,
  input  wire logic ts_lvl,
  // Pins toward the sequencer
  output var logic  link_clk,
  output logic      int_time_pin,
  output logic      second_slope_pin,
  output logic      third_slope_pin
);
  // Link clock, 80 ns, still outside frames, edges fall on clk falling edges
  initial link_clk = 1'b0;
  always #40 link_clk = run ? ~link_clk : 1'b0;
  // Controller drives integration pins itself in slave mode
  assign int_time_pin     = int_lvl;
  assign second_slope_pin = ds_lvl;
  assign third_slope_pin  = ts_lvl;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the readout sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clk, reset_n, psel, penable, pwrite, run, int_lvl, ds_lvl, ts_lvl, err;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 pready, pslverr, link_clk, int_time_pin, second_slope_pin, third_slope_pin;
  rsss_pkg::rsss_slot_t slot_q;
  rsss_pkg::rsss_pix_t  pix_q;
  rsss_pkg::rsss_slot_t q[$];
  int                   error_cnt, check_count, n_ds, n_ts, n_rst, k;
  // Clock
  always #2.5 clk = ~clk;
  // Design and far side
  rsss_sequencer #(.LINE_CYCLES(4)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .int_time_pin(int_time_pin), .second_slope_pin(second_slope_pin),
    .third_slope_pin(third_slope_pin), .slot_q(slot_q), .pix_q(pix_q));
  rsss_link_model u_far (.run(run), .int_lvl(int_lvl), .ds_lvl(ds_lvl), .ts_lvl(ts_lvl), .link_clk(link_clk),
    .int_time_pin(int_time_pin), .second_slope_pin(second_slope_pin), .third_slope_pin(third_slope_pin));
  // Slot and pulse monitor
  always @(posedge clk) begin
    if (slot_q.valid === 1'b1) q.push_back(slot_q);
    if (pix_q.second_slope === 1'b1) n_ds++;
    if (pix_q.third_slope === 1'b1) n_ts++;
    if (pix_q.pix_reset === 1'b1) n_rst++;
  end
  // --------
  // Tasks
  // --------
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Setup cycle, then access held until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) chk("pready_wait", 1, 0);
    if (n >= 50) conclude();
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic win(input logic [1:0] w, input logic [31:0] xs, xk, ys, ye);
    apb(1'b1, {2'h1, w, 4'h0}, xs);
    apb(1'b1, {2'h1, w, 4'h4}, xk);
    apb(1'b1, {2'h1, w, 4'h8}, ys);
    apb(1'b1, {2'h1, w, 4'hc}, ye);
  endtask
  // Start one frame and collect slots until the last window ends
  task automatic frame(input logic [31:0] cfga, input logic [1:0] lastw);
    int n;
    q.delete();
    n_ds = 0;
    n_ts = 0;
    n_rst = 0;
    run <= 1'b1;
    apb(1'b1, rsss_pkg::A_CFG_A, cfga);
    n = 0;
    while (!(q.size() > 0 && q[$].sync === rsss_pkg::SC_FRAME_END && q[$].win === lastw) && n < 20000) begin
      @(posedge clk);
      n++;
    end
    run <= 1'b0;
    if (n >= 20000) chk("frame_wait", 1, 0);
    if (n >= 20000) conclude();
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    {clk, reset_n, psel, penable, pwrite, paddr, pwdata, run, int_lvl, ds_lvl, ts_lvl} = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk("nwin_rst", rsss_pkg::A_NWIN, 32'h1);
    rchk("xk_rst", 8'h44, 32'h36);
    rchk("ye_rst", 8'h4c, 32'h3ff);
    rchk("unmapped_rd", 8'h30, 32'h0);
    chk("unmapped_err", 1, err);
    apb(1'b1, rsss_pkg::A_NWIN, 32'h0);
    rchk("nwin_min", rsss_pkg::A_NWIN, 32'h1);
    apb(1'b1, rsss_pkg::A_RSTLEN, 32'h400);
    apb(1'b1, rsss_pkg::A_TINT, 32'h28);
    apb(1'b1, rsss_pkg::A_DS_TIMER, 32'ha);
    apb(1'b1, rsss_pkg::A_TS_TIMER, 32'h3);
    win(2'h0, 32'h0, 32'h1, 32'h0, 32'h7);
    frame(32'h61, 2'h0);
    chk("rst_len", 1025, n_rst);
    chk("ds_pulse", 1, n_ds);
    chk("ts_pulse", 1, n_ts);
    chk("dummy_fs", rsss_pkg::SC_FRAME_BEGIN, q[0].sync);
    chk("dummy_fpn", rsss_pkg::SC_FPN, q[1].sync);
    chk("win_fs", rsss_pkg::SC_FRAME_BEGIN, q[111].sync);
    chk("u0a_c0", 0, q[112].cols[0]);
    chk("u0a_c11", 22, q[112].cols[11]);
    chk("u0b_c0", 1, q[113].cols[0]);
    chk("gbc_sync", rsss_pkg::SC_GBC, q[114].sync);
    chk("gbc_c0", 1295, q[114].cols[0]);
    chk("crc_sync", rsss_pkg::SC_CRC, q[116].sync);
    win(2'h0, 32'd53, 32'h1, 32'h0, 32'h1);
    frame(32'h1, 2'h0);
    chk("ds_off", 0, n_ds);
    chk("ts_off", 0, n_ts);
    chk("last_sync", rsss_pkg::SC_GBC, q[112].sync);
    chk("last_c0", 1295, q[112].cols[0]);
    chk("last_crc", rsss_pkg::SC_CRC, q[114].sync);
    win(2'h0, 32'h0, 32'h2, 32'h0, 32'h1);
    apb(1'b1, rsss_pkg::A_CFG_D, 32'h3);
    frame(32'h1, 2'h0);
    chk("col_a_c1", 45, q[112].cols[1]);
    chk("col_b_c1", 44, q[113].cols[1]);
    chk("col_p1_c0", 48, q[114].cols[0]);
    chk("col_p1_c1", 93, q[114].cols[1]);
    apb(1'b1, rsss_pkg::A_CFG_D, 32'h1);
    frame(32'h1, 2'h0);
    chk("mono_a_c1", 2, q[112].cols[1]);
    chk("mono_b_c0", 46, q[113].cols[0]);
    apb(1'b1, rsss_pkg::A_CFG_D, 32'hc0);
    win(2'h0, 32'h0, 32'h1, 32'h0, 32'h1);
    frame(32'h1, 2'h0);
    chk("rev_u0_c0", 1295, q[112].cols[0]);
    chk("rev_row", 1022, q[116].row);
    apb(1'b1, rsss_pkg::A_CFG_D, 32'h0);
    apb(1'b1, rsss_pkg::A_NWIN, 32'h2);
    win(2'h1, 32'd53, 32'h1, 32'h4, 32'h5);
    frame(32'h1, 2'h1);
    k = 0;
    while (k < q.size() - 1 && q[k].win !== 2'h1) k++;
    chk("w1_fs", rsss_pkg::SC_FRAME_BEGIN, q[k].sync);
    chk("w0_fe", rsss_pkg::SC_FRAME_END, q[k - 1].sync);
    chk("w0_before", 0, q[k - 1].win);
    k = 0;
    foreach (q[j]) if (q[j].sync === rsss_pkg::SC_FPN) k++;
    chk("dummy_once", 108, k);
    apb(1'b1, rsss_pkg::A_CFG_A, 32'h2);
    {ds_lvl, ts_lvl} <= 2'b11;
    repeat (8) @(posedge clk);
    chk("slave_rst", 1, pix_q.pix_reset);
    chk("slave_ds", 1, pix_q.second_slope);
    chk("slave_ts", 1, pix_q.third_slope);
    int_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    chk("slave_int", 0, pix_q.pix_reset);
    conclude();
  end
endmodule
`default_nettype wire
